// ### hdl/spcs_cfg.svh
// constants of the serial port and configuration store block
// assumes inclusion by bare name from the design file and the bench
`ifndef SPCS_CFG_SVH
`define SPCS_CFG_SVH
`define SPCS_ADDR_CFG 13'h000
`define SPCS_ADDR_COMMIT 13'h232
`define SPCS_ADDR_STAT 13'hB00
`define SPCS_ADDR_ERR 13'hB01
`define SPCS_ADDR_CTRL 13'hB02
`define SPCS_ADDR_STORE 13'hB03
`define SPCS_TOP_ADDR 13'h232
`define SPCS_CFG_RESET 8'h18
`define SPCS_CFG_LSB_LO 1
`define SPCS_CFG_LSB_HI 6
`define SPCS_CFG_SOFT_RST 5
`define SPCS_CFG_UNIDIR 7
`define SPCS_CTRL_WE 0
`define SPCS_CTRL_SOFT_LOAD 1
`define SPCS_COMMIT_BIT 0
`define SPCS_STORE_BIT 0
`define SPCS_OP_COMMIT 8'h80
`define SPCS_OP_END 8'hFF
`define SPCS_NVM_BYTES 512
`define SPCS_NVM_DATA_LEN 9'h1FD
`define SPCS_NVM_LAST_IDX 9'h1FF
`define SPCS_LEN_STREAM 2'h3
`define SPCS_BOOT_WAIT 2'h3
`endif

// ### hdl/spcs_pkg.sv
// types shared by the serial port and configuration store block
// assumes nothing beyond a SystemVerilog compiler
package spcs_pkg;
    typedef enum logic [1:0] {
        SP_INSTR,
        SP_DATA,
        SP_DONE
    } spcs_sp_state_type;
    typedef enum logic [1:0] {
        NV_BOOT,
        NV_IDLE,
        NV_STORE,
        NV_LOAD
    } spcs_nv_state_type;
endpackage : spcs_pkg

// ### hdl/spcs_top.sv
// serial control port and nonvolatile configuration store controller
// assumes a host on cs/sclk/sdio pins, 40 MHz clk_in, sclk far slower
// Overview of operation
// - instruction is 16 bits: read/write bit, two length bits, 13 address bits
// - length code 00/01/10 gives 1/2/3 data bytes, 11 gives streaming
// - port starts most significant bit first after reset
// - bit order change in config register acts at once, no commit
// - msb first: shift high to low, address decrements each byte
// - lsb first: shift low to high, address increments each byte
// - streaming stops at top address, decrement wraps from zero to top
// - address generator steps through every address, none skipped
// - during a store or restore only the busy flag is readable
// - i2c address acknowledge only once the transfer has completed
// - 512 byte store written only by the internal controller
// - store copies registers and opcodes, then clears the store bit
// - busy flag set for the whole store or restore, also on status pin
// - error flag set when a store or restore fails
// - restore pin high: restore on power up, reset or soft reset
// - restore pin low: soft load bit starts a restore
// - restore pin low at reset: defaults loaded, store not read
// - commit copies all buffered writes to active registers together
// - restore treats 0x80 as commit and 0xFF as end of data
`timescale 1ns/100ps
`default_nettype none
`include "spcs_cfg.svh"
module spcs_top #(
    parameter int REG_DEPTH = 'h232
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic sclk_in,
    input wire logic cs_n_in,
    input wire logic sdio_in,
    input wire logic restore_sel_in,
    output logic sdio_out,
    output logic sdio_oe_out,
    output logic sdo_out,
    output logic sdo_oe_out,
    output logic status_out,
    output logic i2c_addr_ack_out
);
    // pin synchronisers
    logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, sd_s1, sd_s2, rsel_s1, rsel_s2;
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            sd_s1 <= 1'b0;
            sd_s2 <= 1'b0;
            rsel_s1 <= 1'b0;
            rsel_s2 <= 1'b0;
        end else begin
            sclk_s1 <= sclk_in;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            cs_s1 <= cs_n_in;
            cs_s2 <= cs_s1;
            sd_s1 <= sdio_in;
            sd_s2 <= sd_s1;
            rsel_s1 <= restore_sel_in;
            rsel_s2 <= rsel_s1;
        end
    end
    logic sclk_rise, sclk_fall;
    assign sclk_rise = sclk_s2 & ~sclk_s3;
    assign sclk_fall = ~sclk_s2 & sclk_s3;

    // register file and store state
    logic [7:0] cfg_reg, cfg_next;
    logic [7:0] bufm_reg [REG_DEPTH];
    logic [7:0] bufm_next [REG_DEPTH];
    logic [7:0] act_reg [REG_DEPTH];
    logic [7:0] act_next [REG_DEPTH];
    logic [7:0] nvm_mem [`SPCS_NVM_BYTES];
    logic we_reg, we_next, store_reg, store_next, err_reg, err_next;
    logic busy_reg, ack_reg;
    logic [8:0] idx_reg, idx_next;
    logic [1:0] boot_reg, boot_next;
    spcs_pkg::spcs_nv_state_type nv_reg, nv_next;
    logic nvm_wr;
    logic [7:0] nvm_wdata;
    logic commit, soft_rst, soft_load;

    // serial engine state
    spcs_pkg::spcs_sp_state_type sp_reg, sp_next;
    logic [3:0] bit_reg, bit_next;
    logic [15:0] instr_reg, instr_next, word_new;
    logic [12:0] addr_reg, addr_next, addr_step;
    logic rw_reg, rw_next;
    logic [1:0] len_reg, len_next, left_reg, left_next;
    logic [7:0] shin_reg, shin_next, shout_reg, shout_next, byte_new;
    logic sdio_next, sdio_oe_next, sdo_next, sdo_oe_next;
    logic wr_req, byte_done, last_byte, lsb;
    logic [7:0] wr_data;

    assign lsb = cfg_reg[`SPCS_CFG_LSB_LO];

    function automatic logic [7:0] rd_byte(input logic [12:0] a);
        logic [7:0] r;
        r = 8'h00;
        if (a == `SPCS_ADDR_STAT) begin
            r = {7'h00, busy_reg};
        end else if (!busy_reg) begin
            if (a == `SPCS_ADDR_CFG) begin
                r = cfg_reg;
            end else if (a < 13'(REG_DEPTH)) begin
                r = act_reg[a[9:0]];
            end else if (a == `SPCS_ADDR_ERR) begin
                r = {7'h00, err_reg};
            end else if (a == `SPCS_ADDR_CTRL) begin
                r = {7'h00, we_reg};
            end else if (a == `SPCS_ADDR_STORE) begin
                r = {7'h00, store_reg};
            end
        end
        return r;
    endfunction : rd_byte

    // serial engine
    always_comb begin
        sp_next = sp_reg;
        bit_next = bit_reg;
        instr_next = instr_reg;
        addr_next = addr_reg;
        rw_next = rw_reg;
        len_next = len_reg;
        left_next = left_reg;
        shin_next = shin_reg;
        shout_next = shout_reg;
        sdio_next = sdio_out;
        sdio_oe_next = sdio_oe_out;
        sdo_next = sdo_out;
        sdo_oe_next = sdo_oe_out;
        wr_req = 1'b0;
        wr_data = 8'h00;
        word_new = lsb ? {sd_s2, instr_reg[15:1]} : {instr_reg[14:0], sd_s2};
        byte_new = lsb ? {sd_s2, shin_reg[7:1]} : {shin_reg[6:0], sd_s2};
        if (lsb) begin
            addr_step = addr_reg + 13'h001;
        end else if (addr_reg == 13'h000) begin
            addr_step = `SPCS_TOP_ADDR;
        end else begin
            addr_step = addr_reg - 13'h001;
        end
        byte_done = !cs_s2 && sclk_rise && sp_reg == spcs_pkg::SP_DATA && bit_reg == 4'h7;
        last_byte = (len_reg == `SPCS_LEN_STREAM) ? (addr_reg == `SPCS_TOP_ADDR)
                                                  : (left_reg == 2'h0);
        if (cs_s2) begin
            sdio_oe_next = 1'b0;
            sdo_oe_next = 1'b0;
            if (bit_reg != 4'h0 || sp_reg == spcs_pkg::SP_DONE
                || len_reg == `SPCS_LEN_STREAM) begin
                sp_next = spcs_pkg::SP_INSTR;
                bit_next = 4'h0;
            end
        end else if (sclk_rise) begin
            case (sp_reg)
                spcs_pkg::SP_INSTR: begin
                    instr_next = word_new;
                    bit_next = bit_reg + 4'h1;
                    if (bit_reg == 4'hF) begin
                        rw_next = word_new[15];
                        len_next = word_new[14:13];
                        left_next = word_new[14:13];
                        addr_next = word_new[12:0];
                        sp_next = spcs_pkg::SP_DATA;
                        bit_next = 4'h0;
                        shout_next = rd_byte(word_new[12:0]);
                    end
                end
                spcs_pkg::SP_DATA: begin
                    shin_next = byte_new;
                    bit_next = bit_reg + 4'h1;
                    if (bit_reg == 4'h7) begin
                        bit_next = 4'h0;
                        wr_req = !rw_reg;
                        wr_data = byte_new;
                        if (last_byte) begin
                            sp_next = spcs_pkg::SP_DONE;
                        end else begin
                            addr_next = addr_step;
                            left_next = left_reg - 2'h1;
                            shout_next = rd_byte(addr_step);
                        end
                    end
                end
                spcs_pkg::SP_DONE: begin
                    bit_next = 4'h0;
                end
                default: begin
                    sp_next = spcs_pkg::SP_INSTR;
                end
            endcase
        end else if (sclk_fall && sp_reg == spcs_pkg::SP_DATA && rw_reg) begin
            shout_next = lsb ? {1'b0, shout_reg[7:1]} : {shout_reg[6:0], 1'b0};
            if (cfg_reg[`SPCS_CFG_UNIDIR]) begin
                sdo_next = lsb ? shout_reg[0] : shout_reg[7];
                sdo_oe_next = 1'b1;
            end else begin
                sdio_next = lsb ? shout_reg[0] : shout_reg[7];
                sdio_oe_next = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sp_reg <= spcs_pkg::SP_INSTR;
            bit_reg <= 4'h0;
            instr_reg <= 16'h0000;
            addr_reg <= 13'h0000;
            rw_reg <= 1'b0;
            len_reg <= 2'h0;
            left_reg <= 2'h0;
            shin_reg <= 8'h00;
            shout_reg <= 8'h00;
            sdio_out <= 1'b0;
            sdio_oe_out <= 1'b0;
            sdo_out <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else begin
            sp_reg <= sp_next;
            bit_reg <= bit_next;
            instr_reg <= instr_next;
            addr_reg <= addr_next;
            rw_reg <= rw_next;
            len_reg <= len_next;
            left_reg <= left_next;
            shin_reg <= shin_next;
            shout_reg <= shout_next;
            sdio_out <= sdio_next;
            sdio_oe_out <= sdio_oe_next;
            sdo_out <= sdo_next;
            sdo_oe_out <= sdo_oe_next;
        end
    end

    // register writes, commit and store controller
    always_comb begin
        cfg_next = cfg_reg;
        bufm_next = bufm_reg;
        act_next = act_reg;
        we_next = we_reg;
        store_next = store_reg;
        err_next = err_reg;
        nv_next = nv_reg;
        idx_next = idx_reg;
        boot_next = boot_reg;
        nvm_wr = 1'b0;
        nvm_wdata = 8'h00;
        commit = 1'b0;
        soft_rst = 1'b0;
        soft_load = 1'b0;
        if (wr_req && !busy_reg) begin
            if (addr_reg == `SPCS_ADDR_CFG) begin
                cfg_next = wr_data;
                cfg_next[`SPCS_CFG_SOFT_RST] = 1'b0;
                soft_rst = wr_data[`SPCS_CFG_SOFT_RST];
            end else if (addr_reg == `SPCS_ADDR_COMMIT) begin
                commit = wr_data[`SPCS_COMMIT_BIT];
            end else if (addr_reg == `SPCS_ADDR_CTRL) begin
                we_next = wr_data[`SPCS_CTRL_WE];
                soft_load = wr_data[`SPCS_CTRL_SOFT_LOAD];
            end else if (addr_reg == `SPCS_ADDR_STORE) begin
                store_next = wr_data[`SPCS_STORE_BIT];
            end else if (addr_reg < 13'(REG_DEPTH)) begin
                bufm_next[addr_reg[9:0]] = wr_data;
            end
        end
        if (commit) begin
            act_next = bufm_next;
        end
        case (nv_reg)
            spcs_pkg::NV_BOOT: begin
                boot_next = boot_reg + 2'h1;
                idx_next = 9'h000;
                if (boot_reg == `SPCS_BOOT_WAIT) begin
                    nv_next = rsel_s2 ? spcs_pkg::NV_LOAD : spcs_pkg::NV_IDLE;
                end
            end
            spcs_pkg::NV_IDLE: begin
                idx_next = 9'h000;
                if (soft_rst) begin
                    cfg_next = `SPCS_CFG_RESET;
                    for (int i = 0; i < REG_DEPTH; i++) begin
                        bufm_next[i] = 8'h00;
                        act_next[i] = 8'h00;
                    end
                    if (rsel_s2) begin
                        nv_next = spcs_pkg::NV_LOAD;
                        err_next = 1'b0;
                    end
                end else if (soft_load && !rsel_s2) begin
                    nv_next = spcs_pkg::NV_LOAD;
                    err_next = 1'b0;
                end else if (commit && store_next) begin
                    if (we_reg) begin
                        nv_next = spcs_pkg::NV_STORE;
                        err_next = 1'b0;
                    end else begin
                        err_next = 1'b1;
                        store_next = 1'b0;
                    end
                end
            end
            spcs_pkg::NV_STORE: begin
                nvm_wr = 1'b1;
                idx_next = idx_reg + 9'h001;
                if (idx_reg < `SPCS_NVM_DATA_LEN) begin
                    nvm_wdata = (idx_reg == 9'h000) ? cfg_reg : act_reg[idx_reg];
                end else if (idx_reg == `SPCS_NVM_DATA_LEN) begin
                    nvm_wdata = `SPCS_OP_COMMIT;
                end else begin
                    nvm_wdata = `SPCS_OP_END;
                    store_next = 1'b0;
                    nv_next = spcs_pkg::NV_IDLE;
                end
            end
            spcs_pkg::NV_LOAD: begin
                idx_next = idx_reg + 9'h001;
                if (idx_reg < `SPCS_NVM_DATA_LEN) begin
                    if (idx_reg != 9'h000) begin
                        bufm_next[idx_reg] = nvm_mem[idx_reg];
                    end
                end else if (nvm_mem[idx_reg] == `SPCS_OP_COMMIT) begin
                    act_next = bufm_next;
                    if (idx_reg == `SPCS_NVM_LAST_IDX) begin
                        err_next = 1'b1;
                        nv_next = spcs_pkg::NV_IDLE;
                    end
                end else if (nvm_mem[idx_reg] == `SPCS_OP_END) begin
                    nv_next = spcs_pkg::NV_IDLE;
                end else begin
                    err_next = 1'b1;
                    nv_next = spcs_pkg::NV_IDLE;
                end
            end
            default: begin
                nv_next = spcs_pkg::NV_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            cfg_reg <= `SPCS_CFG_RESET;
            for (int i = 0; i < REG_DEPTH; i++) begin
                bufm_reg[i] <= 8'h00;
                act_reg[i] <= 8'h00;
            end
            we_reg <= 1'b0;
            store_reg <= 1'b0;
            err_reg <= 1'b0;
            nv_reg <= spcs_pkg::NV_BOOT;
            idx_reg <= 9'h000;
            boot_reg <= 2'h0;
            busy_reg <= 1'b1;
            ack_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            bufm_reg <= bufm_next;
            act_reg <= act_next;
            we_reg <= we_next;
            store_reg <= store_next;
            err_reg <= err_next;
            nv_reg <= nv_next;
            idx_reg <= idx_next;
            boot_reg <= boot_next;
            busy_reg <= nv_next != spcs_pkg::NV_IDLE;
            ack_reg <= nv_next == spcs_pkg::NV_IDLE;
        end
    end

    // nonvolatile contents survive reset
    always_ff @(posedge clk_in) begin
        if (nvm_wr) begin
            nvm_mem[idx_reg] <= nvm_wdata;
        end
    end

    assign status_out = busy_reg;
    assign i2c_addr_ack_out = ack_reg;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_instr_done;
        !cs_s2 && sclk_rise && sp_reg == spcs_pkg::SP_INSTR && bit_reg == 4'hF;
    endsequence
    sequence s_mid_byte;
        byte_done && !last_byte;
    endsequence
    chk_instr_addr: assert property (s_instr_done |=> sp_reg == spcs_pkg::SP_DATA
        && addr_reg == $past(word_new[12:0]) && rw_reg == $past(word_new[15]))
        else $error("instruction word not decoded");
    chk_len_code: assert property (s_instr_done |=> left_reg == $past(word_new[14:13]))
        else $error("length code not taken");
    chk_order_now: assert property (wr_req && !busy_reg && addr_reg == `SPCS_ADDR_CFG
        && !wr_data[`SPCS_CFG_SOFT_RST] |=> lsb == $past(wr_data[1]))
        else $error("bit order change not immediate");
    chk_addr_down: assert property (s_mid_byte ##0 !lsb && addr_reg != 13'h000
        |=> addr_reg == $past(addr_reg) - 13'h001)
        else $error("address did not decrement");
    chk_addr_up: assert property (s_mid_byte ##0 lsb
        |=> addr_reg == $past(addr_reg) + 13'h001)
        else $error("address did not increment");
    chk_stream_stop: assert property (byte_done && len_reg == 2'h3
        && addr_reg == 13'h232 |=> sp_reg == spcs_pkg::SP_DONE)
        else $error("streaming did not stop at top");
    chk_busy_block: assert property (busy_reg && wr_req |=> cfg_reg == $past(cfg_reg)
        && we_reg == $past(we_reg))
        else $error("write accepted while busy");
    chk_store_clear: assert property (nv_reg == spcs_pkg::NV_STORE
        && idx_reg == 9'h1FE |=> !store_reg ##1 !busy_reg)
        else $error("store bit not cleared at end");
    chk_busy_start: assert property (nv_reg == spcs_pkg::NV_IDLE
        && nv_next != spcs_pkg::NV_IDLE |=> busy_reg && status_out && !i2c_addr_ack_out)
        else $error("busy not raised at start");
    chk_done_hold: assert property (sp_reg == spcs_pkg::SP_DONE && !cs_s2
        |=> sp_reg == spcs_pkg::SP_DONE)
        else $error("sclk not ignored after stop");
endmodule : spcs_top
`default_nettype wire

// ### tb/spcs_host.sv
// host model driving the serial control port pins
// assumes the bench resolves the shared data line from both enables
`timescale 1ns/100ps
`default_nettype none
module spcs_host (
    input wire logic miso_in,
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out
);
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // while reading, the released line toggles each bit instead of holding a value
    task automatic shift(input logic [15:0] v, input int nb, input logic lsb,
        input logic rd_en, output logic [15:0] r);
        int k;
        r = 16'h0000;
        for (int i = 0; i < nb; i++) begin
            k = lsb ? i : nb - 1 - i;
            mosi_out = rd_en ? ~mosi_out : v[k];
            #100 sclk_out = 1'b1;
            #95 r[k] = miso_in;
            #5 sclk_out = 1'b0;
        end
    endtask : shift
    task automatic frame(input logic rw, input logic [1:0] len, input logic [12:0] adr,
        input int n, input logic lsb, input logic [31:0] wd, output logic [31:0] rd);
        logic [15:0] r;
        rd = 32'h00000000;
        cs_n_out = 1'b0;
        #100 shift({rw, len, adr}, 16, lsb, 1'b0, r);
        for (int b = 0; b < n; b++) begin
            shift({8'h00, wd[8*b +: 8]}, 8, lsb, rw, r);
            rd[8*b +: 8] = r[7:0];
        end
        #100 cs_n_out = 1'b1;
        #400;
    endtask : frame
endmodule : spcs_host
`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the serial port and configuration store block
// assumes the host model and the design constants header
`timescale 1ns/100ps
`default_nettype none
`include "spcs_cfg.svh"
module tb;
    logic clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic restore_sel_in = 1'b0;
    wire logic sclk, cs_n, mosi, sdio_out, sdio_oe_out, sdo_out, sdo_oe_out, status_out, ack;
    wire logic sdio_w;
    wire logic miso;
    int miscompares = 0;
    int samples_checked = 0;
    int seed = 92022;
    logic [31:0] rd;
    assign sdio_w = sdio_oe_out ? sdio_out : mosi;
    assign miso = sdo_oe_out ? sdo_out : sdio_w;
    always #12.5 clk_in = ~clk_in;
    spcs_top spcs_top_i (.clk_in(clk_in), .nrst_in(nrst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .sdio_in(sdio_w), .restore_sel_in(restore_sel_in), .sdio_out(sdio_out),
        .sdio_oe_out(sdio_oe_out), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
        .status_out(status_out), .i2c_addr_ack_out(ack));
    spcs_host spcs_host_i (.miso_in(miso), .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_busy(input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && status_out !== lvl; i++) begin
            @(posedge clk_in);
        end
        if (i == bound) begin
            miscompares++;
            $display("[ERR] %0t busy flag wait expired", $time);
            end_of_test();
        end
    endtask : wait_busy
    task automatic xf(input logic rw, input logic [1:0] len, input logic [12:0] a,
        input int n, input logic lsb, input logic [31:0] wd);
        @(posedge clk_in);
        #1 spcs_host_i.frame(rw, len, a, n, lsb, wd, rd);
    endtask : xf
    task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic lsb);
        xf(1'b0, 2'h0, a, 1, lsb, {24'h000000, d});
    endtask : wr
    task automatic rb(input logic [12:0] a, input logic lsb, input logic [7:0] exp);
        xf(1'b1, 2'h0, a, 1, lsb, 32'h00000000);
        chk(rd, {24'h000000, exp});
    endtask : rb
    task automatic do_reset(input logic sel);
        @(posedge clk_in);
        #1 restore_sel_in = sel;
        nrst_in = 1'b0;
        repeat (4) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        wait_busy(1'b0, 2000);
    endtask : do_reset
    initial begin
        logic [12:0] a;
        logic [31:0] d;
        logic [7:0] v;
        repeat (4) @(posedge clk_in);
        #1 nrst_in = 1'b1;
        wait_busy(1'b0, 20);
        chk({31'h0, ack}, 32'h1);
        rb(`SPCS_ADDR_CFG, 1'b0, 8'h18);
        for (int len = 0; len < 3; len++) begin
            a = 13'h040 * 13'(len + 1) + 13'($random(seed) & 32'h3F);
            d = $random(seed);
            xf(1'b0, 2'(len), a, len + 1, 1'b0, d);
            rb(a, 1'b0, 8'h00);
            wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
            xf(1'b1, 2'(len), a, len + 1, 1'b0, 32'h0);
            chk(rd, d & ~(32'hFFFFFFFF << (8 * len + 8)));
            rb(a - 13'(len), 1'b0, d[8*len +: 8]);
        end
        wr(13'h300, 8'hA5, 1'b0);
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        rb(13'h300, 1'b0, 8'h00);
        v = $random(seed);
        xf(1'b0, 2'h1, 13'h002, 2, 1'b0, {16'h0, ~v, v});
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        xf(1'b1, 2'h3, 13'h002, 4, 1'b0, 32'h0);
        chk(rd, {8'h00, 8'h18, ~v, v});
        xf(1'b0, 2'h3, 13'h001, 4, 1'b0, {8'h5A, 8'h01, 8'h18, v});
        rb(13'h001, 1'b0, v);
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        rb(13'h231, 1'b0, 8'h00);
        wr(`SPCS_ADDR_CFG, 8'h81, 1'b0);
        rb(13'h001, 1'b0, v);
        wr(`SPCS_ADDR_CFG, 8'h18, 1'b0);
        wr(`SPCS_ADDR_CFG, 8'h5A, 1'b0);
        rb(`SPCS_ADDR_CFG, 1'b1, 8'h5A);
        d = $random(seed);
        xf(1'b0, 2'h3, 13'h22F, 4, 1'b1, {8'h01, d[23:0]});
        xf(1'b1, 2'h2, 13'h22F, 3, 1'b1, 32'h0);
        chk(rd, {8'h00, d[23:0]});
        wr(`SPCS_ADDR_CFG, 8'h18, 1'b1);
        wr(`SPCS_ADDR_CTRL, 8'h01, 1'b0);
        wr(`SPCS_ADDR_STORE, 8'h01, 1'b0);
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        wait_busy(1'b1, 10);
        chk({31'h0, ack}, 32'h0);
        rb(`SPCS_ADDR_STAT, 1'b0, 8'h01);
        rb(13'h001, 1'b0, 8'h00);
        wait_busy(1'b0, 2000);
        rb(`SPCS_ADDR_STORE, 1'b0, 8'h00);
        rb(`SPCS_ADDR_ERR, 1'b0, 8'h00);
        wr(`SPCS_ADDR_CTRL, 8'h00, 1'b0);
        wr(`SPCS_ADDR_STORE, 8'h01, 1'b0);
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        rb(`SPCS_ADDR_ERR, 1'b0, 8'h01);
        rb(`SPCS_ADDR_STORE, 1'b0, 8'h00);
        wr(13'h001, ~v, 1'b0);
        wr(`SPCS_ADDR_COMMIT, 8'h01, 1'b0);
        wr(`SPCS_ADDR_CTRL, 8'h02, 1'b0);
        wait_busy(1'b1, 10);
        wait_busy(1'b0, 2000);
        rb(13'h001, 1'b0, v);
        do_reset(1'b1);
        rb(13'h001, 1'b0, v);
        do_reset(1'b0);
        rb(13'h001, 1'b0, 8'h00);
        @(posedge clk_in);
        #1 restore_sel_in = 1'b1;
        wr(`SPCS_ADDR_CFG, 8'h3C, 1'b0);
        wait_busy(1'b0, 2000);
        rb(13'h001, 1'b0, v);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
